// ---- inc/otfr_pkg.sv ----
// constants, types and delay tables of the overtemp fault responder
package otfr_pkg;

  // ****************************************************************
  // register
  // ****************************************************************
  localparam logic [7:0] CFG_OFFSET = 8'h50;
  localparam logic [7:0] CFG_RESET  = 8'h00;

  // ****************************************************************
  // field layout, bit 7 down to bit 0
  // ****************************************************************
  typedef enum logic [1:0] {
    ACT_IGNORE    = 2'h0,
    ACT_DELAYED   = 2'h1,
    ACT_IMMEDIATE = 2'h2,
    ACT_HOLD      = 2'h3
  } otfr_action_type;

  typedef struct packed {
    otfr_action_type action;  // bits [7:6]
    logic [2:0]      retry;   // bits [5:3]
    logic [2:0]      delay;   // bits [2:0]
  } otfr_cfg_type;

  localparam logic [2:0] RETRY_NONE     = 3'h0;
  localparam logic [2:0] RETRY_INFINITE = 3'h7;

  // ****************************************************************
  // sequencer states and status carrier
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_DELAY    = 3'h1,
    ST_OFF_WAIT = 3'h2,
    ST_RESTART  = 3'h3,
    ST_LATCHED  = 3'h4,
    ST_HOLD     = 3'h5
  } otfr_state_type;

  typedef struct packed {
    logic           fault_latched;
    logic           retry_active;
    logic           holding;
    logic [2:0]     attempts;
    otfr_state_type state;
  } otfr_status_type;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_PERIOD_NS  = 1000000;
  localparam int CYCLES_PER_MS =
    (MS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [11:0] SHUTDOWN_BASE_MS = 12'h00a;

  // shutdown delay doubles with each code step
  function automatic logic [11:0] otfr_shutdown_ms(
    input logic [2:0] code
  );
    return SHUTDOWN_BASE_MS << code;
  endfunction : otfr_shutdown_ms

  // restart interval in ms
  function automatic logic [11:0] otfr_restart_ms(
    input logic [2:0] code
  );
    logic [11:0] ms;
    ms = 12'h0fc;
    case (code)
      3'h0:    ms = 12'h0fc;
      3'h1:    ms = 12'h22e;
      3'h2:    ms = 12'h39c;
      3'h3:    ms = 12'h4ec;
      3'h4:    ms = 12'h63c;
      3'h5:    ms = 12'h78c;
      3'h6:    ms = 12'h8dc;
      default: ms = 12'ha2c;
    endcase
    return ms;
  endfunction : otfr_restart_ms

endpackage : otfr_pkg

// ---- logic/otfr_ms_tick.sv ----
// millisecond tick divider with restart for the fault responder
`timescale 1ns/1ps
module otfr_ms_tick #(
  parameter int CYCLES_PER_MS = otfr_pkg::CYCLES_PER_MS
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // control
  input  wire logic restart,
  // tick out
  output logic      tick
);

  logic [31:0] count;

  // restart aligns the phase so a timed wait is never cut short
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 32'h0000_0000;
      tick  <= 1'b0;
    end else if (restart) begin
      count <= 32'h0000_0000;
      tick  <= 1'b0;
    end else if (count == 32'(CYCLES_PER_MS - 1)) begin
      count <= 32'h0000_0000;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h0000_0001;
      tick  <= 1'b0;
    end
  end

endmodule : otfr_ms_tick

// ---- logic/otfr_responder.sv ----
// overtemperature fault response sequencer with its action register
`timescale 1ns/1ps

// Functional notes
// - action bits 7:6, code 00 ignores fault
// - code 01: run through delay, then retry
// - code 10: shut down now, then retry
// - code 11: off while fault, then re-enable
// - retry field gives attempts, 111 is unlimited
// - retries spent: output stays off, latched
// - reset clears latched fault condition
// - restart attempts spaced by restart interval
// - shutdown delay from fault to disable
// - delay codes map to fixed ms tables
module otfr_responder #(
  parameter int CYCLES_PER_MS = otfr_pkg::CYCLES_PER_MS
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // action register port
  input  wire logic                  reg_wr,
  input  wire logic [7:0]            reg_wdata,
  output logic [7:0]                 reg_rdata,
  // fault detector side
  input  wire logic                  ot_fault,
  // converter side
  output logic                       conv_out_en,
  // status
  output otfr_pkg::otfr_status_type  status
);

  // ****************************************************************
  // action register
  // ****************************************************************
  otfr_pkg::otfr_cfg_type cfg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= otfr_pkg::otfr_cfg_type'(otfr_pkg::CFG_RESET);
    end else if (reg_wr) begin
      cfg <= otfr_pkg::otfr_cfg_type'(reg_wdata);
    end
  end

  // live config: a write mid-sequence steers the later steps
  assign reg_rdata = cfg;

  // ****************************************************************
  // millisecond timer
  // ****************************************************************
  logic        ms_tick;
  logic        timer_load;
  logic [11:0] timer_value;
  logic [11:0] ms_left;
  logic        timer_done;

  // divider restart costs at most two cycles per timed wait
  otfr_ms_tick #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_tick (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .restart (timer_load),
    .tick    (ms_tick)
  );

  // counts whole ms; zero means the wait is over
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ms_left <= 12'h000;
    end else if (timer_load) begin
      ms_left <= timer_value;
    end else if (ms_tick && ms_left != 12'h000) begin
      ms_left <= ms_left - 12'h001;
    end
  end

  assign timer_done = (ms_left == 12'h000);

  // ****************************************************************
  // sequencer
  // ****************************************************************
  otfr_pkg::otfr_state_type state;
  otfr_pkg::otfr_state_type next_state;
  logic [2:0]               attempts;
  logic [2:0]               next_attempts;
  logic                     retries_spent;

  // unlimited setting never exhausts the attempt budget
  assign retries_spent = (cfg.retry != otfr_pkg::RETRY_INFINITE) &&
                         (attempts >= cfg.retry);

  always_comb begin
    next_state    = state;
    next_attempts = attempts;
    timer_load    = 1'b0;
    timer_value   = otfr_pkg::otfr_restart_ms(cfg.delay);
    case (state)
      otfr_pkg::ST_IDLE: begin
        next_attempts = 3'h0;
        if (ot_fault) begin
          case (cfg.action)
            otfr_pkg::ACT_IGNORE: begin
              next_state = otfr_pkg::ST_IDLE;
            end
            otfr_pkg::ACT_DELAYED: begin
              timer_load  = 1'b1;
              timer_value = otfr_pkg::otfr_shutdown_ms(cfg.delay);
              next_state  = otfr_pkg::ST_DELAY;
            end
            otfr_pkg::ACT_IMMEDIATE: begin
              if (cfg.retry == otfr_pkg::RETRY_NONE) begin
                next_state = otfr_pkg::ST_LATCHED;
              end else begin
                timer_load = 1'b1;
                next_state = otfr_pkg::ST_OFF_WAIT;
              end
            end
            default: begin
              next_state = otfr_pkg::ST_HOLD;
            end
          endcase
        end
      end
      otfr_pkg::ST_DELAY: begin
        if (!ot_fault) begin
          next_state = otfr_pkg::ST_IDLE;
        end else if (timer_done) begin
          if (cfg.retry == otfr_pkg::RETRY_NONE) begin
            next_state = otfr_pkg::ST_LATCHED;
          end else begin
            timer_load = 1'b1;
            next_state = otfr_pkg::ST_OFF_WAIT;
          end
        end
      end
      otfr_pkg::ST_OFF_WAIT: begin
        if (timer_done) begin
          next_state = otfr_pkg::ST_RESTART;
          if (cfg.retry != otfr_pkg::RETRY_INFINITE) begin
            next_attempts = attempts + 3'h1;
          end
        end
      end
      otfr_pkg::ST_RESTART: begin
        // one enabled cycle, then judge the attempt on the fault
        if (!ot_fault) begin
          next_state = otfr_pkg::ST_IDLE;
        end else if (retries_spent) begin
          next_state = otfr_pkg::ST_LATCHED;
        end else begin
          timer_load = 1'b1;
          next_state = otfr_pkg::ST_OFF_WAIT;
        end
      end
      otfr_pkg::ST_LATCHED: begin
        next_state = otfr_pkg::ST_LATCHED;
      end
      otfr_pkg::ST_HOLD: begin
        if (!ot_fault) begin
          next_state = otfr_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = otfr_pkg::ST_IDLE;
      end
    endcase
  end

  // only reset leaves the latched state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= otfr_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      attempts <= 3'h0;
    end else begin
      attempts <= next_attempts;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // registered from next state, so the enable pin never glitches
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      conv_out_en <= 1'b1;
    end else begin
      case (next_state)
        otfr_pkg::ST_OFF_WAIT: conv_out_en <= 1'b0;
        otfr_pkg::ST_LATCHED:  conv_out_en <= 1'b0;
        otfr_pkg::ST_HOLD:     conv_out_en <= 1'b0;
        default:               conv_out_en <= 1'b1;
      endcase
    end
  end

  // status follows next state so it lines up with the enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '{fault_latched: 1'b0, retry_active: 1'b0,
                  holding: 1'b0, attempts: 3'h0,
                  state: otfr_pkg::ST_IDLE};
    end else begin
      status.fault_latched <= (next_state == otfr_pkg::ST_LATCHED);
      status.retry_active  <= (next_state == otfr_pkg::ST_OFF_WAIT) ||
                              (next_state == otfr_pkg::ST_RESTART);
      status.holding       <= (next_state == otfr_pkg::ST_HOLD);
      status.attempts      <= next_attempts;
      status.state         <= next_state;
    end
  end

endmodule : otfr_responder

// ---- tb/otfr_fault_model.sv ----
// temperature detector model that drives the fault level
`timescale 1ns/1ps
module otfr_fault_model #(
  parameter logic [7:0] LIMIT = 8'h7d
) (
  // clock
  input  wire logic       mclk,
  // temperature in
  input  wire logic [7:0] temp,
  // fault out
  output logic            ot_fault
);
  // registered compare, so the level only moves just after an edge
  always_ff @(posedge mclk) begin
    ot_fault <= temp > LIMIT;
  end
endmodule : otfr_fault_model

// ---- tb/otfr_properties.sv ----
// port checker for the overtemp fault responder
`timescale 1ns/1ps
module otfr_properties #(
  parameter int CYCLES_PER_MS = 4
) (
  // clock and reset
  input wire logic                      mclk,
  input wire logic                      rst_n,
  // register and fault
  input wire logic                      reg_wr,
  input wire logic [7:0]                reg_wdata,
  input wire logic [7:0]                reg_rdata,
  input wire logic                      ot_fault,
  // outputs
  input wire logic                      conv_out_en,
  input wire otfr_pkg::otfr_status_type status
);
  // state codes: 0 idle, 1 delay, 2 off, 3 restart, 4 latched, 5 hold
  wire logic [2:0] st = status.state;
  wire logic [1:0] act = reg_rdata[7:6];
  wire logic hit = ot_fault && !reg_wr && st == 3'h0;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  chk_write_lands: assert property (
    reg_wr |=> reg_rdata == $past(reg_wdata)) else $error("write lost");
  chk_ignore_runs: assert property (
    act == 2'h0 && hit |=> st == 3'h0 && conv_out_en) else $error("ignore");
  chk_delay_on: assert property (
    st == 3'h1 |-> conv_out_en) else $error("off during delay");
  chk_delay_drop: assert property (
    st == 3'h1 && !ot_fault |=> st == 3'h0) else $error("delay drop");
  chk_cut_now: assert property (
    act == 2'h2 && reg_rdata[5:3] != 3'h0 && hit |=> !conv_out_en
    && st == 3'h2) else $error("no immediate cut");
  chk_hold_off: assert property (
    act == 2'h3 && hit |=> !conv_out_en && st == 3'h5) else $error("hold");
  chk_hold_back: assert property (
    st == 3'h5 && !ot_fault |=> conv_out_en) else $error("no re-enable");
  chk_retry_pulse: assert property (
    st == 3'h3 |-> conv_out_en ##1 st != 3'h3) else $error("restart");
  chk_latch_kept: assert property (
    st == 3'h4 |=> st == 3'h4 && !conv_out_en) else $error("latch lost");
  chk_flags_match: assert property (
    status.fault_latched == (st == 3'h4) && status.holding == (st == 3'h5)
    && status.retry_active == (st == 3'h2 || st == 3'h3))
    else $error("status flags");
  chk_attempt_step: assert property (
    $changed(status.attempts) && status.attempts != 3'h0 |-> st == 3'h3)
    else $error("attempt count moved outside restart");
endmodule : otfr_properties

bind otfr_responder otfr_properties #(
  .CYCLES_PER_MS(CYCLES_PER_MS)
) i_otfr_properties (
  .mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .ot_fault(ot_fault),
  .conv_out_en(conv_out_en), .status(status));

// ---- tb/overtemp_fault_responder_bench.sv ----
// self-checking bench for the overtemp fault responder
`timescale 1ns/1ps
module overtemp_fault_responder_bench;
  // ****************************************************************
  // signals and design
  // ****************************************************************
  localparam int CPM = 4;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] temp = 8'h00;
  logic [7:0] reg_rdata;
  logic       ot_fault;
  logic       conv_out_en;
  logic       prev = 1'b1;
  logic [2:0] d;
  logic       q_v[$];
  int         q_t[$];
  int         rt[8] = '{252, 558, 924, 1260, 1596, 1932, 2268, 2604};
  int         errors = 0;
  int         num_checks = 0;
  int         cyc = 0;
  int         last = 0;
  int         seed = 32'hf5bb_5137;
  otfr_pkg::otfr_status_type status;

  always #5 mclk = ~mclk;

  otfr_responder #(.CYCLES_PER_MS(CPM)) i_otfr_responder (
    .mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .ot_fault(ot_fault),
    .conv_out_en(conv_out_en), .status(status));
  otfr_fault_model i_otfr_fault_model (
    .mclk(mclk), .temp(temp), .ot_fault(ot_fault));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  task automatic fail(input string msg);
    errors++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask : fail

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) fail("value mismatch");
  endtask : chk_byte

  // output edge against the oldest note; slack covers the tick phase
  task automatic chk_edge(input logic v, input int dt);
    logic ev;
    int   et;
    num_checks++;
    if (q_v.size() == 0) begin
      fail("unexpected output change");
    end else begin
      ev = q_v.pop_front();
      et = q_t.pop_front();
      if (v !== ev || dt < et || dt > et + 3) fail("output edge");
    end
  endtask : chk_edge

  task automatic chk_status(input logic lat, input logic hold,
                            input logic [2:0] n);
    num_checks++;
    if (status.fault_latched !== lat || status.holding !== hold ||
        status.attempts !== n) fail("status mismatch");
  endtask : chk_status

  task automatic note(input logic v, input int dt);
    q_v.push_back(v);
    q_t.push_back(dt);
  endtask : note

  task automatic wr(input logic [7:0] b);
    reg_wr = 1'b1;
    reg_wdata = b;
    step(1);
    reg_wr = 1'b0;
    chk_byte(reg_rdata, b);
    step(1);
  endtask : wr

  // detector registers the level, design sees it one edge later
  task automatic heat(input logic on);
    int r;
    r = $random(seed);
    temp = on ? (8'h80 | r[7:0]) : (8'h3f & r[7:0]);
    if (on) last = cyc + 3;
  endtask : heat

  task automatic reboot();
    rst_n = 1'b0;
    step(2);
    rst_n = 1'b1;
    chk_byte({7'h00, conv_out_en}, 8'h01);
    chk_byte(reg_rdata, 8'h00);
    chk_status(1'b0, 1'b0, 3'h0);
  endtask : reboot

  // ****************************************************************
  // monitor and scenarios
  // ****************************************************************
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 60000) begin
      fail("timeout");
      stop_test();
    end else begin
      if (rst_n && conv_out_en !== prev) begin
        chk_edge(conv_out_en, cyc - last);
        last = cyc;
      end
      prev = conv_out_en;
    end
  end

  initial begin
    step(6);
    rst_n = 1'b1;
    chk_byte(reg_rdata, 8'h00);
    heat(1);
    step(20);
    heat(0);
    step(4);
    wr(8'hc0);
    heat(1);
    note(1'b0, 0);
    step(30);
    chk_status(1'b0, 1'b1, 3'h0);
    heat(0);
    note(1'b1, 30);
    step(6);
    d = 3'($random(seed));
    wr({2'h1, 3'h1, d});
    heat(1);
    step(20);
    heat(0);
    step(6);
    heat(1);
    note(1'b0, (10 << d) * CPM);
    note(1'b1, rt[d] * CPM);
    note(1'b0, 1);
    step(((10 << d) + rt[d]) * CPM + 20);
    chk_status(1'b1, 1'b0, 3'h1);
    heat(0);
    step(10);
    reboot();
    d = 3'($random(seed));
    wr({2'h2, 3'h2, d});
    heat(1);
    note(1'b0, 0);
    repeat (2) begin
      note(1'b1, rt[d] * CPM);
      note(1'b0, 1);
    end
    step(2 * rt[d] * CPM + 20);
    chk_status(1'b1, 1'b0, 3'h2);
    heat(0);
    step(10);
    reboot();
    wr(8'hb8);
    heat(1);
    note(1'b0, 0);
    repeat (7) begin
      note(1'b1, rt[0] * CPM);
      note(1'b0, 1);
    end
    note(1'b1, rt[0] * CPM);
    step(7 * (rt[0] * CPM + 2) + 20);
    heat(0);
    step(rt[0] * CPM + 20);
    chk_status(1'b0, 1'b0, 3'h0);
    wr(8'h80);
    heat(1);
    note(1'b0, 0);
    step(20);
    chk_status(1'b1, 1'b0, 3'h0);
    heat(0);
    step(10);
    num_checks++;
    if (q_v.size() != 0) fail("missing output change");
    stop_test();
  end
endmodule : overtemp_fault_responder_bench
